// ### logic/ser_pkg.sv
/*
 Constants shared by the clocked serial unit and its clock generator.
 Assumes an 8-bit special function register bus with 16-bit addresses.
*/
// Functional notes
// R1 - Three modes: stopped, three-line, two-line
// R2 - Three-line: 8 bits out and in together
// R3 - Most significant bit always goes first
// R4 - Two-line: clock plus one shared data line
// R5 - Shift register converts, stepped by serial clock
// R6 - Start needs enable; write, or receive-only read
// R7 - Transmit drives written byte onto data output
// R8 - Receive captures data input into shift register
// R9 - Shift register resets zero, byte access only
// R10 - Software avoids shift register during transfer
// R11 - Enable low: stop, clear counter, release pins
// R12 - Mode bit picks transmit/receive or receive-only
// R13 - Clock select: external, timer, /8, /128
// R14 - Mode register layout, zero bits, bit writes
// R15 - Wire register bit 0 picks two-line mode
// R16 - Shared pin direction follows mode bit
// R17 - Data input stays free when only sending
// R18 - After eight bits stop, park clock, flag
// R19 - Change data on fall, sample on rise
package ser_pkg;
    localparam logic [15:0] MODE_ADDR = 16'hffaa;
    localparam logic [15:0] WIRE_ADDR = 16'hffab;
    localparam logic [15:0] DATA_ADDR = 16'hffac;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [7:0] MODE_MASK = 8'h87;
    localparam logic [7:0] WIRE_MASK = 8'h01;
    localparam int EN_BIT = 7;
    localparam int RX_BIT = 2;
    localparam int TWO_BIT = 0;
    localparam logic [1:0] SEL_EXT = 2'h0;
    localparam logic [1:0] SEL_TMR = 2'h1;
    localparam logic [1:0] SEL_DIV8 = 2'h2;
    localparam logic [1:0] SEL_DIV128 = 2'h3;
    localparam int DIV8 = 8;
    localparam int DIV128 = 128;
    localparam logic [5:0] HALF8 = 6'(DIV8 / 2 - 1);
    localparam logic [5:0] HALF128 = 6'(DIV128 / 2 - 1);
    localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// ### logic/sclk_if.sv
/*
 Signals between the serial unit core and its clock generator.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface sclk_if;
    logic [1:0] sel;
    logic run;
    logic ext_lvl;
    logic tmr_lvl;
    logic fall;
    logic rise;
    logic sck;
    modport gen (input sel, input run, input ext_lvl, input tmr_lvl,
        output fall, output rise, output sck);
    modport core (output sel, output run, output ext_lvl, output tmr_lvl,
        input fall, input rise, input sck);
endinterface

// ### logic/sclk_gen.sv
/*
 Serial clock generator: divides the system clock or follows an
 external or timer clock, and reports falling and rising edges.
 Assumes the external level is already synchronised.
*/
`timescale 1ns/1ns
module sclk_gen
(
    input wire logic clk,
    input wire logic rst_n,
    sclk_if.gen s
);
    logic [5:0] div_r;
    logic sck_r;
    logic prev_r;
    logic fall_r;
    logic rise_r;
    logic internal;
    logic src_lvl;
    logic [5:0] half;
    logic tgl;

    // Source and divider terminal count
    assign internal = (s.sel == ser_pkg::SEL_DIV8) || (s.sel == ser_pkg::SEL_DIV128);
    assign src_lvl = (s.sel == ser_pkg::SEL_EXT) ? s.ext_lvl : s.tmr_lvl;
    assign half = (s.sel == ser_pkg::SEL_DIV8) ? ser_pkg::HALF8 : ser_pkg::HALF128;
    assign tgl = s.run && internal && (div_r == half);

    // Half period counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= 6'h00;
        else if (!s.run || !internal || tgl)
            div_r <= 6'h00;
        else
            div_r <= div_r + 6'h01;
    end

    // Serial clock level, parked high when idle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sck_r <= 1'b1;
        else if (!s.run)
            sck_r <= 1'b1; // R18
        else if (tgl)
            sck_r <= !sck_r; // R13
        else if (!internal)
            sck_r <= src_lvl;
    end

    // Edge pulses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_r <= 1'b1;
            fall_r <= 1'b0;
            rise_r <= 1'b0;
        end
        else
        begin
            prev_r <= src_lvl;
            fall_r <= s.run && (internal ? (tgl && sck_r) : (prev_r && !src_lvl));
            rise_r <= s.run && (internal ? (tgl && !sck_r) : (!prev_r && src_lvl));
        end
    end

    assign s.fall = fall_r;
    assign s.rise = rise_r;
    assign s.sck = sck_r;

    // Clock parks high whenever not running
    property p_park_high;
        @(posedge clk) disable iff (!rst_n)
        !s.run |=> s.sck;
    endproperty
    a_park_high: assert property (p_park_high) else $error("sck not parked"); // R18

    // Divide by eight gives rise four cycles after fall
    property p_div8_half;
        @(posedge clk) disable iff (!rst_n)
        (s.fall && s.run && s.sel == ser_pkg::SEL_DIV8) |->
            ##1 (!s.rise)[*3] ##1 (s.rise || !s.run);
    endproperty
    a_div8_half: assert property (p_div8_half) else $error("bad /8 half"); // R13
endmodule // sclk_gen

// ### logic/serial_unit.sv
/*
 Clocked serial unit with three-line and two-line modes, MSB first,
 with mode, wire-count and shift registers on the SFR bus.
 Assumes single-cycle SFR strobes on clk and open pins outside.
*/
`timescale 1ns/1ns
module serial_unit
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    output logic [7:0] sfr_rdata,
    input wire logic timer_output_clock,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_n,
    input wire logic serial_data_out_pin_in,
    output logic serial_data_out_pin_out,
    output logic serial_data_out_pin_oe_n,
    input wire logic serial_data_in_pin,
    output logic transfer_done_irq
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } st_e;

    st_e st_r;
    st_e st_nxt;
    logic [7:0] mode_r;
    logic [7:0] wire_r;
    logic [7:0] sh_r;
    logic [2:0] cnt_r;
    logic so_r;
    logic done_r;
    logic [7:0] rdata_r;
    logic sck_out_r;
    logic sck_oe_n_r;
    logic dout_oe_n_r;
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] filt_r;
    logic [2:0] agree;
    logic en;
    logic rx_only;
    logic two_wire;
    logic internal;
    logic din;
    logic wr_mode;
    logic wr_wire;
    logic wr_data;
    logic rd_data;
    logic start;
    logic last;

    sclk_if sif ();

    //------------------------------------------------------------
    // Field decode
    //------------------------------------------------------------

    // Mode fields and access strobes
    assign en = mode_r[ser_pkg::EN_BIT];
    assign rx_only = mode_r[ser_pkg::RX_BIT]; // R12
    assign two_wire = wire_r[ser_pkg::TWO_BIT]; // R15
    assign internal = (sif.sel == ser_pkg::SEL_DIV8) || (sif.sel == ser_pkg::SEL_DIV128);
    assign wr_mode = (sfr_wr || sfr_bit_wr) && sfr_addr == ser_pkg::MODE_ADDR;
    assign wr_wire = (sfr_wr || sfr_bit_wr) && sfr_addr == ser_pkg::WIRE_ADDR;
    assign wr_data = sfr_wr && sfr_addr == ser_pkg::DATA_ADDR; // R9
    assign rd_data = sfr_rd && sfr_addr == ser_pkg::DATA_ADDR;

    // Start: write in transmit/receive, read in receive-only
    assign start = en && st_r == ST_IDLE
        && (rx_only ? rd_data : wr_data); // R6
    assign last = sif.rise && cnt_r == ser_pkg::LAST_BIT;

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------

    // Three stages; a change counts once stages two and three agree
    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            s3_r <= 3'h7;
            filt_r <= 3'h7;
        end
        else
        begin
            s1_r <= {serial_clock_pin_in, serial_data_out_pin_in, serial_data_in_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s3_r & agree) | (filt_r & ~agree);
        end
    end

    // Receive line: shared pin in two-line mode, else input pin
    assign din = two_wire ? filt_r[1] : filt_r[0]; // R4 R17

    //------------------------------------------------------------
    // Clock generator
    //------------------------------------------------------------

    // Run only while shifting
    assign sif.sel = mode_r[1:0];
    assign sif.run = st_r == ST_SHIFT;
    assign sif.ext_lvl = filt_r[2];
    assign sif.tmr_lvl = timer_output_clock;

    sclk_gen u_gen
    (
        .clk(clk),
        .rst_n(rst_n),
        .s(sif.gen)
    );

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------

    // Mode register, byte or bit writable, zeros in bits 6-3
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_r <= ser_pkg::RST_VAL;
        else if (wr_mode && sfr_wr)
            mode_r <= sfr_wdata & ser_pkg::MODE_MASK; // R14
        else if (wr_mode)
        begin
            mode_r[sfr_bit_idx] <= sfr_bit_val & ser_pkg::MODE_MASK[sfr_bit_idx];
        end
    end

    // Wire-count register, only bit 0 stored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wire_r <= ser_pkg::RST_VAL;
        else if (wr_wire && sfr_wr)
            wire_r <= sfr_wdata & ser_pkg::WIRE_MASK; // R15
        else if (wr_wire)
        begin
            wire_r[sfr_bit_idx] <= sfr_bit_val & ser_pkg::WIRE_MASK[sfr_bit_idx];
        end
    end

    // Read data, unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= ser_pkg::RST_VAL;
        else if (sfr_rd)
        begin
            unique case (sfr_addr)
                ser_pkg::MODE_ADDR: rdata_r <= mode_r;
                ser_pkg::WIRE_ADDR: rdata_r <= wire_r;
                ser_pkg::DATA_ADDR: rdata_r <= sh_r; // R8
                default: rdata_r <= ser_pkg::RST_VAL;
            endcase
        end
    end

    //------------------------------------------------------------
    // Transfer control
    //------------------------------------------------------------

    // State sequence
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: if (start) st_nxt = ST_SHIFT;
            ST_SHIFT: if (last) st_nxt = ST_IDLE; // R18
            default: st_nxt = ST_IDLE;
        endcase
        if (!en)
            st_nxt = ST_IDLE; // R11 R1
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= ST_IDLE;
        else
            st_r <= st_nxt;
    end

    // Bit counter, cleared while disabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= 3'h0;
        else if (!en || start)
            cnt_r <= 3'h0; // R11
        else if (st_r == ST_SHIFT && sif.rise)
            cnt_r <= cnt_r + 3'h1;
    end

    // Shift register: load idle writes unless receive-only, shift in on rising edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sh_r <= ser_pkg::RST_VAL; // R9
        else if (wr_data && st_r == ST_IDLE && !rx_only)
            sh_r <= sfr_wdata; // R10 R7
        else if (st_r == ST_SHIFT && en && sif.rise)
            sh_r <= {sh_r[6:0], din}; // R2 R3 R5 R8 R19
    end

    // Output latch takes the MSB on the falling edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            so_r <= 1'b0;
        else if (st_r == ST_SHIFT && sif.fall)
            so_r <= sh_r[7]; // R3 R7 R19
    end

    // Completion pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            done_r <= 1'b0;
        else
            done_r <= st_r == ST_SHIFT && en && last; // R18
    end

    //------------------------------------------------------------
    // Pin drivers
    //------------------------------------------------------------

    // Clock driven only from an internal source while enabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_out_r <= 1'b1;
            sck_oe_n_r <= 1'b1;
            dout_oe_n_r <= 1'b1;
        end
        else
        begin
            sck_out_r <= sif.sck;
            sck_oe_n_r <= !(en && internal); // R13 R11
            dout_oe_n_r <= !(en && !rx_only); // R12 R16 R4
        end
    end

    assign serial_clock_pin_out = sck_out_r;
    assign serial_clock_pin_oe_n = sck_oe_n_r;
    assign serial_data_out_pin_out = so_r;
    assign serial_data_out_pin_oe_n = dout_oe_n_r;
    assign sfr_rdata = rdata_r;
    assign transfer_done_irq = done_r;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    // Write start in transmit/receive mode
    property p_wr_start;
        @(posedge clk) disable iff (!rst_n)
        (wr_data && en && !rx_only && st_r == ST_IDLE) |=> st_r == ST_SHIFT;
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("no write start"); // R6

    // Read start in receive-only mode
    property p_rd_start;
        @(posedge clk) disable iff (!rst_n)
        (rd_data && en && rx_only && st_r == ST_IDLE) |=> st_r == ST_SHIFT;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("no read start"); // R6

    // Disable stops transfer and clears counter
    property p_disable;
        @(posedge clk) disable iff (!rst_n)
        !en |=> (st_r == ST_IDLE && cnt_r == 3'h0);
    endproperty
    a_disable: assert property (p_disable) else $error("not stopped"); // R11

    // Eighth rising edge ends the transfer with one pulse
    sequence s_last_edge;
        st_r == ST_SHIFT && en && sif.rise && cnt_r == ser_pkg::LAST_BIT;
    endsequence
    sequence s_finish;
        transfer_done_irq && st_r == ST_IDLE ##1 !transfer_done_irq;
    endsequence
    property p_done;
        @(posedge clk) disable iff (!rst_n)
        s_last_edge |=> s_finish;
    endproperty
    a_done: assert property (p_done) else $error("bad completion"); // R18

    // Output latch shows the MSB after a falling edge
    property p_msb_out;
        @(posedge clk) disable iff (!rst_n)
        (st_r == ST_SHIFT && sif.fall) |=> so_r == $past(sh_r[7]);
    endproperty
    a_msb_out: assert property (p_msb_out) else $error("bad out bit"); // R19

    // Rising edge shifts the sampled input into bit 0
    property p_shift_in;
        @(posedge clk) disable iff (!rst_n)
        (st_r == ST_SHIFT && en && sif.rise) |=>
            (sh_r[0] == $past(din) && sh_r[7:1] == $past(sh_r[6:0]));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("bad shift in"); // R5

    // Receive-only releases the data output pin
    property p_rx_release;
        @(posedge clk) disable iff (!rst_n)
        (rx_only || !en) |=> serial_data_out_pin_oe_n;
    endproperty
    a_rx_release: assert property (p_rx_release) else $error("pin held"); // R16

    // Mode register reads zero in bits 6-3
    property p_mode_zero;
        @(posedge clk) disable iff (!rst_n)
        (sfr_rd && sfr_addr == ser_pkg::MODE_ADDR) |=> sfr_rdata[6:3] == 4'h0;
    endproperty
    a_mode_zero: assert property (p_mode_zero) else $error("bits 6-3 set"); // R14

    // Bit writes never change the shift register
    property p_no_bit_data;
        @(posedge clk) disable iff (!rst_n)
        (sfr_bit_wr && sfr_addr == ser_pkg::DATA_ADDR && st_r == ST_IDLE)
            |=> sh_r == $past(sh_r);
    endproperty
    a_no_bit_data: assert property (p_no_bit_data) else $error("bit write"); // R9
endmodule // serial_unit

// ### dv/serial_peer.sv
/*
 Far-side model: clock-synchronous serial peer, MSB first.
 Assumes the bench resolves pin levels and pulses load before a frame.
*/
`timescale 1ns/1ns
module serial_peer
(
    input wire logic clk,
    input wire logic sck,
    input wire logic line_in,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic ext_go,
    output logic ext_sck = 1'b1,
    output logic bit_out = 1'b1,
    output logic [7:0] rx_byte = 8'h00
);
    logic [7:0] tx_r = 8'h00;
    logic sck_q = 1'b1;
    int cnt = 8;
    int hold = 13;
    int ext_n = 0;
    int ext_t = 0;
    // ---------------------------------------------
    // Shift on pin edges, invert the held line bit after frame
    // ---------------------------------------------
    always @(posedge clk)
    begin
        sck_q <= sck;
        if (load)
        begin
            tx_r <= load_val;
            cnt <= 0;
            hold <= 0;
        end
        else if (sck_q && !sck && cnt < 8)
        begin
            bit_out <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
        end
        else if (!sck_q && sck && cnt < 8)
        begin
            rx_byte <= {rx_byte[6:0], line_in};
            cnt <= cnt + 1;
        end
        else if (cnt == 8 && hold < 12)
            hold <= hold + 1;
        else if (cnt == 8 && hold == 12)
        begin
            bit_out <= ~bit_out; // Hold over: show the inverse
            hold <= 13;
        end
    end
    // Slave-side clock source: eight pulses, idles high
    always @(posedge clk)
    begin
        ext_t <= (ext_go || ext_t == 19) ? 0 : ext_t + 1;
        if (ext_go)
            ext_n <= 16;
        else if (ext_n > 0 && ext_t == 19)
        begin
            ext_sck <= ~ext_sck;
            ext_n <= ext_n - 1;
        end
    end
endmodule // serial_peer

// ### dv/tb.sv
/*
 Self-checking bench: registers, every clock source, both wire counts
 and abort. Assumes the peer model and the design package.
*/
`timescale 1ns/1ns
module tb;
    // ---------------------------------------------
    // Signals
    // ---------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] sfr_addr = 16'h0000;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_idx = 3'h0;
    logic sfr_bit_val = 1'b0;
    logic [7:0] sfr_rdata, prx, v;
    logic [7:0] ld_v = 8'h00;
    logic [3:0] tdiv = 4'h0;
    logic sck_out, sck_oe_n, sd_out, sd_oe_n, irq, sck_w, sd_w, pbit, esck;
    logic two = 1'b0;
    logic load = 1'b0;
    logic go = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int per;
    bit hit;
    // Clock and a free-running timer source
    always #10 clk = ~clk;
    always @(negedge clk) tdiv <= tdiv + 4'h1;
    // Pin levels from every driver
    assign sck_w = sck_oe_n ? esck : sck_out;
    assign sd_w = sd_oe_n ? pbit : sd_out;
    serial_unit i_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
        .sfr_rdata(sfr_rdata), .timer_output_clock(tdiv[3]),
        .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe_n(sck_oe_n), .serial_data_out_pin_in(sd_w),
        .serial_data_out_pin_out(sd_out), .serial_data_out_pin_oe_n(sd_oe_n),
        .serial_data_in_pin(two ? ~pbit : pbit), .transfer_done_irq(irq));
    serial_peer i_peer (.clk(clk), .sck(sck_w), .line_in(sd_w), .load(load),
        .load_val(ld_v), .ext_go(go), .ext_sck(esck), .bit_out(pbit), .rx_byte(prx));
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail = n_fail + 1;
            end_of_test();
        end
    end
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task automatic end_of_test;
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic b);
        @(negedge clk);
        sfr_addr = a;
        sfr_bit_idx = i;
        sfr_bit_val = b;
        sfr_bit_wr = 1'b1;
        @(negedge clk);
        sfr_bit_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic rc(input string n, input logic [15:0] a, input logic [7:0] e);
        rd(a, v);
        chk(n, v, e);
    endtask
    // Wait for the done pulse; measure the clock pin period
    task automatic wait_done(output int p, output bit h);
        int t1;
        logic q;
        t1 = -1;
        p = 0;
        h = 1'b0;
        q = 1'b1;
        for (int i = 0; i < 2500 && !h; i++)
        begin
            @(negedge clk);
            if (q && !sck_w && t1 >= 0 && p == 0)
                p = i - t1;
            if (q && !sck_w && t1 < 0)
                t1 = i;
            q = sck_w;
            h = (irq === 1'b1);
        end
    endtask
    // One frame: mode, peer byte, start trigger, completion
    task automatic xf(input logic [7:0] m, input logic [7:0] d, input logic [7:0] p);
        wr(ser_pkg::MODE_ADDR, m);
        @(negedge clk);
        ld_v = p;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        if (m[2])
            rd(ser_pkg::DATA_ADDR, v);
        else
            wr(ser_pkg::DATA_ADDR, d);
        go = (m[1:0] == 2'h0);
        @(negedge clk);
        go = 1'b0;
        wait_done(per, hit);
        // Peer has taken the last bit by two clocks after the done pulse
        repeat (2) @(negedge clk);
        chk("done", {7'h0, hit}, 8'h01);
    endtask
    // ---------------------------------------------
    // Sequence
    // ---------------------------------------------
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk("pins", {4'h0, sck_out, sck_oe_n, sd_oe_n, irq}, 8'h0e);
        rc("mode", ser_pkg::MODE_ADDR, 8'h00);
        rc("wire", ser_pkg::WIRE_ADDR, 8'h00);
        rc("data", ser_pkg::DATA_ADDR, 8'h00);
        wr(ser_pkg::MODE_ADDR, 8'hff);
        rc("mode", ser_pkg::MODE_ADDR, 8'h87);
        wr(ser_pkg::WIRE_ADDR, 8'hff);
        rc("wire", ser_pkg::WIRE_ADDR, 8'h01);
        wr(ser_pkg::WIRE_ADDR, 8'h00);
        rc("unmapped", 16'hffff, 8'h00);
        bw(ser_pkg::MODE_ADDR, 3'h7, 1'b0);
        bw(ser_pkg::MODE_ADDR, 3'h0, 1'b0);
        rc("mode", ser_pkg::MODE_ADDR, 8'h06);
        bw(ser_pkg::DATA_ADDR, 3'h0, 1'b1);
        rc("data", ser_pkg::DATA_ADDR, 8'h00);
        // Data written while stopped never starts a frame
        wr(ser_pkg::MODE_ADDR, 8'h03);
        wr(ser_pkg::DATA_ADDR, 8'ha5);
        wr(ser_pkg::MODE_ADDR, 8'h83);
        wait_done(per, hit);
        chk("start", {7'h0, hit}, 8'h00);
        xf(8'h83, 8'ha5, 8'h3c);
        chk("per", 8'(per), 8'h80);
        chk("peer", prx, 8'ha5);
        rc("data", ser_pkg::DATA_ADDR, 8'h3c);
        chk("sck", {7'h0, sck_w}, 8'h01);
        xf(8'h82, 8'h5a, 8'h00);
        chk("per", 8'(per), 8'h08);
        chk("peer", prx, 8'h5a);
        xf(8'h87, 8'h00, 8'h96);
        chk("sdoe", {7'h0, sd_oe_n}, 8'h01);
        wr(ser_pkg::MODE_ADDR, 8'h07);
        rc("data", ser_pkg::DATA_ADDR, 8'h96);
        two = 1'b1;
        wr(ser_pkg::WIRE_ADDR, 8'h01);
        xf(8'h83, 8'hc3, 8'h00);
        chk("peer", prx, 8'hc3);
        xf(8'h87, 8'h00, 8'h69);
        wr(ser_pkg::MODE_ADDR, 8'h07);
        rc("data", ser_pkg::DATA_ADDR, 8'h69);
        two = 1'b0;
        wr(ser_pkg::WIRE_ADDR, 8'h00);
        // Clearing enable mid-frame aborts and frees the pins
        wr(ser_pkg::MODE_ADDR, 8'h83);
        wr(ser_pkg::DATA_ADDR, 8'h77);
        repeat (200) @(negedge clk);
        wr(ser_pkg::MODE_ADDR, 8'h03);
        repeat (3) @(negedge clk);
        chk("oe", {6'h0, sck_oe_n, sd_oe_n}, 8'h03);
        wait_done(per, hit);
        chk("abort", {7'h0, hit}, 8'h00);
        xf(8'h83, 8'h77, 8'h00);
        chk("peer", prx, 8'h77);
        xf(8'h80, 8'he1, 8'h5c);
        chk("peer", prx, 8'he1);
        rc("data", ser_pkg::DATA_ADDR, 8'h5c);
        xf(8'h81, 8'h1e, 8'h00);
        chk("sckoe", {7'h0, sck_oe_n}, 8'h01);
        end_of_test();
    end
endmodule // tb
